/* hdl/asout_delay.sv */
`timescale 1ns/1ps
// Sample-period delay line with selectable tap for mode latency
module asout_delay
    import asout_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int W = 2 * SAMPLE_BITS + 1
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic adv,
    input wire logic [3:0] tap,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [W-1:0] out_q, out_d;

    always_comb begin
        mem_d = mem_q;
        out_d = out_q;
        if (adv) begin
            mem_d[0] = din;
            for (int i = 1; i < DEPTH; i++) begin
                mem_d[i] = mem_q[i-1];
            end
            out_d = mem_q[tap - 4'h1];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            out_q <= '0;
        end else if (ce) begin
            mem_q <= mem_d;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule : asout_delay

/* hdl/asout_pkg.sv */
package asout_pkg;
    // Sample and frame geometry
    localparam int SAMPLE_BITS = 24;
    localparam int BCLK_PER_FRAME = 64;
    localparam int BCLK_PER_HALF = 32;
    // Speed mode sample rate bounds in Hz
    localparam int SS_FS_MIN_HZ = 2000;
    localparam int SS_FS_MAX_HZ = 54000;
    localparam int DS_FS_MAX_HZ = 108000;
    localparam int QS_FS_MAX_HZ = 216000;
    // Latency in output sample periods per speed mode
    localparam logic [3:0] LAT_SS = 4'hc;
    localparam logic [3:0] LAT_DS = 4'h9;
    localparam logic [3:0] LAT_QS = 4'h5;
    // High-pass shift, one value for every speed mode; corner scales with Fs
    localparam logic [4:0] HPF_SHIFT = 5'h0f;
    // Overflow hold in sample periods: 2^17 - 1
    localparam int OVF_HOLD_BITS = 17;
    localparam logic [16:0] OVF_HOLD = 17'h1ffff;
    // Master bit clock divider: high and low phases in mclk cycles
    localparam logic [7:0] DIV50_HI = 8'h01;
    localparam logic [7:0] DIV50_LO = 8'h01;
    localparam logic [7:0] DIV33_HI = 8'h01;
    localparam logic [7:0] DIV33_LO = 8'h02;
    localparam logic [4:0] BIT_LAST = 5'h1f;
    localparam logic [4:0] MSB_IDX = 5'h17;

    typedef enum logic [1:0] {
        ASOUT_SPEED_SS = 2'b00,
        ASOUT_SPEED_DS = 2'b01,
        ASOUT_SPEED_QS = 2'b10
    } asout_speed_t;

    typedef struct packed {
        logic master;
        logic i2s;
        logic divider_duty_select;
        logic hpf_enable;
        asout_speed_t speed;
    } asout_cfg_t;

    typedef struct packed {
        logic [SAMPLE_BITS-1:0] left;
        logic [SAMPLE_BITS-1:0] right;
        logic overrange;
    } asout_smp_t;
endpackage : asout_pkg

/* hdl/asout_top.sv */
`timescale 1ns/1ps
// What this block does
// - Single-speed mode serves 2 to 54 kHz.
// - Double-speed mode serves above 54 up to 108 kHz.
// - Quad-speed mode serves above 108 up to 216 kHz.
// - Latency is 12, 9 or 5 sample periods by speed mode.
// - Filter edges scale with sample rate; response same within a mode.
// - High-pass corner and settling scale with sample rate.
// - Overflow flag holds 2^17-1 sample periods after overrange.
// - Master mode makes bit clock at 64 times sample rate.
// - Master bit clock duty 50 percent, or 33 percent when selected.
// - Frame clock and data change away from bit clock rising edges.
module asout_top
    import asout_pkg::*;
#(
    parameter int LAT_DEPTH = 16
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire asout_cfg_t cfg,
    input wire logic smp_valid,
    input wire asout_smp_t smp,
    input wire logic bclk_in,
    input wire logic frame_clock_in,
    output logic bclk_out,
    output logic bclk_oe,
    output logic frame_clock_out,
    output logic frame_clock_oe,
    output logic serial_sample_out,
    output logic overrange_flag
);
    // ==========================================================
    // Decimated sample path: high-pass and latency
    // ==========================================================
    localparam int W = 2 * SAMPLE_BITS + 1;

    function automatic logic [3:0] lat_of(input asout_speed_t s);
        unique case (s)
            ASOUT_SPEED_SS: lat_of = LAT_SS;
            ASOUT_SPEED_DS: lat_of = LAT_DS;
            ASOUT_SPEED_QS: lat_of = LAT_QS;
            default: lat_of = LAT_SS;
        endcase
    endfunction : lat_of

    function automatic logic [SAMPLE_BITS-1:0] hpf_out(
        input logic [SAMPLE_BITS-1:0] x,
        input logic [SAMPLE_BITS+15:0] acc
    );
        hpf_out = x - acc[SAMPLE_BITS+15:16];
    endfunction : hpf_out

    // One-pole offset tracker updated per sample: corner and settling scale with Fs
    logic [SAMPLE_BITS+15:0] accl_q, accl_d, accr_q, accr_d;
    logic [W-1:0] hp_word, dly_word;
    logic [SAMPLE_BITS-1:0] hl, hr;

    always_comb begin
        hl = cfg.hpf_enable ? hpf_out(smp.left, accl_q) : smp.left;
        hr = cfg.hpf_enable ? hpf_out(smp.right, accr_q) : smp.right;
        accl_d = accl_q;
        accr_d = accr_q;
        if (smp_valid && cfg.hpf_enable) begin
            accl_d = accl_q + (SAMPLE_BITS+16)'($signed({hl, 16'h0000}) >>> HPF_SHIFT);
            accr_d = accr_q + (SAMPLE_BITS+16)'($signed({hr, 16'h0000}) >>> HPF_SHIFT);
        end
        hp_word = {hl, hr, smp.overrange};
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            accl_q <= '0;
            accr_q <= '0;
        end else if (ce) begin
            accl_q <= accl_d;
            accr_q <= accr_d;
        end
    end

    // Filter edges follow Fs since everything advances once per sample
    asout_delay #(.DEPTH(LAT_DEPTH), .W(W)) u_delay (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .adv(smp_valid),
        .tap(lat_of(cfg.speed)),
        .din(hp_word),
        .dout(dly_word)
    );

    // ==========================================================
    // Overrange hold-out
    // ==========================================================
    logic [OVF_HOLD_BITS-1:0] ovf_cnt_q, ovf_cnt_d;

    always_comb begin
        ovf_cnt_d = ovf_cnt_q;
        if (smp_valid) begin
            if (dly_word[0]) begin
                ovf_cnt_d = OVF_HOLD;
            end else if (ovf_cnt_q != '0) begin
                ovf_cnt_d = ovf_cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ovf_cnt_q <= '0;
        end else if (ce) begin
            ovf_cnt_q <= ovf_cnt_d;
        end
    end

    assign overrange_flag = (ovf_cnt_q != '0);

    // ==========================================================
    // Master bit clock divider
    // ==========================================================
    logic [7:0] div_q, div_d;
    logic bclk_q, bclk_d;

    always_comb begin
        div_d = div_q + 8'h01;
        bclk_d = bclk_q;
        if (bclk_q) begin
            if (div_q + 8'h01 >= (cfg.divider_duty_select ? DIV33_HI : DIV50_HI)) begin
                div_d = 8'h00;
                bclk_d = 1'b0;
            end
        end else if (div_q + 8'h01 >= (cfg.divider_duty_select ? DIV33_LO : DIV50_LO)) begin
            div_d = 8'h00;
            bclk_d = 1'b1;
        end
        if (!cfg.master) begin
            div_d = 8'h00;
            bclk_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            div_q <= 8'h00;
            bclk_q <= 1'b0;
        end else if (ce) begin
            div_q <= div_d;
            bclk_q <= bclk_d;
        end
    end

    // ==========================================================
    // Serial framing: change on falling bit clock edge
    // ==========================================================
    logic bclk_in_q;
    logic fall_e, frm_level;
    logic [5:0] bit_q, bit_d;
    logic frm_q, frm_d, sdo_q, sdo_d, frm_prev_q, frm_prev_d;
    logic [SAMPLE_BITS-1:0] shl_q, shl_d, shr_q, shr_d;
    logic [5:0] pos;

    always_ff @(posedge mclk) begin
        if (srst) begin
            bclk_in_q <= 1'b0;
        end else if (ce) begin
            bclk_in_q <= bclk_in;
        end
    end

    // Master: act where own clock falls; slave: where external clock falls
    assign fall_e = cfg.master ? (bclk_q && !bclk_d && ce) : (bclk_in_q && !bclk_in);
    assign frm_level = cfg.master ? frm_q : frame_clock_in;

    always_comb begin
        bit_d = bit_q;
        frm_d = frm_q;
        frm_prev_d = frm_prev_q;
        sdo_d = sdo_q;
        shl_d = shl_q;
        shr_d = shr_q;
        pos = 6'h00;
        if (fall_e) begin
            if (cfg.master) begin
                bit_d = bit_q + 6'h01;
                frm_d = bit_d[5];
            end else begin
                bit_d = (frame_clock_in != frm_prev_q) ? 6'h00 : bit_q + 6'h01;
            end
            frm_prev_d = frm_level;
            // Load both words once, at the left-half start, so a pair never splits
            if (bit_d == 6'h00 && (cfg.master || !frm_level)) begin
                shl_d = dly_word[W-1 -: SAMPLE_BITS];
                shr_d = dly_word[SAMPLE_BITS:1];
            end
            pos = {1'b0, bit_d[4:0]} - (cfg.i2s ? 6'h01 : 6'h00);
            if (pos <= {1'b0, MSB_IDX} && !(cfg.i2s && bit_d[4:0] == 5'h00)) begin
                sdo_d = (cfg.master ? bit_d[5] : frm_level)
                    ? shr_d[MSB_IDX - pos[4:0]] : shl_d[MSB_IDX - pos[4:0]];
            end else begin
                sdo_d = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            bit_q <= 6'h3f;
            frm_q <= 1'b1;
            frm_prev_q <= 1'b0;
            sdo_q <= 1'b0;
            shl_q <= '0;
            shr_q <= '0;
        end else if (ce) begin
            bit_q <= bit_d;
            frm_q <= frm_d;
            frm_prev_q <= frm_prev_d;
            sdo_q <= sdo_d;
            shl_q <= shl_d;
            shr_q <= shr_d;
        end
    end

    assign bclk_out = bclk_q;
    assign bclk_oe = cfg.master;
    assign frame_clock_out = frm_q;
    assign frame_clock_oe = cfg.master;
    assign serial_sample_out = sdo_q;

    // ==========================================================
    // Checks
    // ==========================================================
    ovf_set_a: assert property (@(posedge mclk) disable iff (srst)
        ce && smp_valid && dly_word[0] |=> overrange_flag)
        else $error("overflow flag not set");
    ovf_hold_a: assert property (@(posedge mclk) disable iff (srst)
        ce && !smp_valid && overrange_flag |=> overrange_flag)
        else $error("overflow flag dropped between samples");
    bclk_high_a: assert property (@(posedge mclk) disable iff (srst)
        ce && cfg.master && $rose(bclk_q) && !cfg.divider_duty_select |=> !bclk_q)
        else $error("bit clock high phase wrong");
    frame_stable_a: assert property (@(posedge mclk) disable iff (srst)
        cfg.master && $changed(frm_q) |-> $fell(bclk_q))
        else $error("frame clock moved off falling edge");
    data_edge_a: assert property (@(posedge mclk) disable iff (srst)
        cfg.master && $changed(sdo_q) |-> $fell(bclk_q))
        else $error("data moved off falling edge");
    oe_mode_a: assert property (@(posedge mclk) disable iff (srst)
        bclk_oe == cfg.master && frame_clock_oe == cfg.master && (cfg.master || !bclk_out))
        else $error("pin enable mismatch");
    i2s_lead_a: assert property (@(posedge mclk) disable iff (srst)
        ce && cfg.master && cfg.i2s && fall_e && bit_d[4:0] == 5'h00 |=> !serial_sample_out)
        else $error("i2s first slot not blank");
    dly_hold_a: assert property (@(posedge mclk) disable iff (srst)
        ce && !smp_valid |=> $stable(dly_word))
        else $error("delay line moved between samples");
endmodule : asout_top

/* sim/asout_host.sv */
`timescale 1ns/1ps
// =====================================================================
// Receiving host: samples the port, and makes slave clocks on request
module asout_host
    import asout_pkg::*;
(
    input wire logic mclk,
    input wire logic gen,
    input wire logic i2s,
    input wire logic bclk,
    input wire logic frame_clock,
    input wire logic data,
    output logic gen_bclk,
    output logic gen_frame,
    output logic got,
    output logic [SAMPLE_BITS-1:0] got_left,
    output logic [SAMPLE_BITS-1:0] got_right
);
    logic [8:0] div_q = 9'h000;
    logic [5:0] idx = 6'h00;
    logic [5:0] cur;
    logic prev_fc = 1'b1;
    logic full = 1'b0;
    logic [SAMPLE_BITS-1:0] sh_l, sh_r;
    // Clocks stand still while not generating; 8 mclk per bit, 64 bits per frame
    always @(posedge mclk) div_q <= gen ? div_q + 9'h001 : 9'h000;
    assign gen_bclk = gen & div_q[2];
    assign gen_frame = gen ? div_q[8] : 1'b1;
    initial got = 1'b0;
    always @(posedge bclk) begin
        cur = (frame_clock != prev_fc) ? 6'h00 : idx;
        got <= 1'b0;
        if (frame_clock != prev_fc && !frame_clock) begin
            if (full) begin
                got <= 1'b1;
                got_left <= sh_l;
                got_right <= sh_r;
            end
            full <= 1'b1;
        end
        if (cur >= {5'h00, i2s} && cur < 6'h18 + {5'h00, i2s}) begin
            if (frame_clock) sh_r <= {sh_r[SAMPLE_BITS-2:0], data};
            else sh_l <= {sh_l[SAMPLE_BITS-2:0], data};
        end
        idx <= cur + 6'h01;
        prev_fc <= frame_clock;
    end
endmodule : asout_host

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
    import asout_pkg::*;
    logic mclk = 1'b0, srst = 1'b1, ce = 1'b1, smp_valid = 1'b0, gen = 1'b0, started = 1'b0;
    asout_cfg_t cfg = '0;
    asout_smp_t smp = '0;
    logic bclk_out, bclk_oe, fc_out, fc_oe, sdata, ovf, g_bclk, g_frame, got, prev_b = 1'b0;
    logic [SAMPLE_BITS-1:0] got_l, got_r;
    logic [79:0] exp_q[$];
    logic [79:0] e;
    int n_fail = 0, n_compared = 0, tick = 0, cycles = 0, run_len = 0, nb = 0, d;
    logic fc_prev = 1'b1;
    wire logic bclk_w = bclk_oe ? bclk_out : g_bclk;
    wire logic fc_w = fc_oe ? fc_out : g_frame;
    asout_top dut_u (.mclk(mclk), .srst(srst), .ce(ce), .cfg(cfg), .smp_valid(smp_valid),
        .smp(smp), .bclk_in(bclk_w), .frame_clock_in(fc_w), .bclk_out(bclk_out),
        .bclk_oe(bclk_oe), .frame_clock_out(fc_out), .frame_clock_oe(fc_oe),
        .serial_sample_out(sdata), .overrange_flag(ovf));
    asout_host host_u (.mclk(mclk), .gen(gen), .i2s(cfg.i2s), .bclk(bclk_w), .frame_clock(fc_w),
        .data(sdata), .gen_bclk(g_bclk), .gen_frame(g_frame), .got(got), .got_left(got_l),
        .got_right(got_r));
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    // =====================================================================
    // Checking
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : cmp
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    function automatic int lat_of(input asout_speed_t s);
        if (s == ASOUT_SPEED_SS) return int'(LAT_SS);
        if (s == ASOUT_SPEED_DS) return int'(LAT_DS);
        return int'(LAT_QS);
    endfunction : lat_of
    always @(negedge got) begin
        if (exp_q.size() != 0 && (started || got_l != '0)) begin
            started = 1'b1;
            e = exp_q.pop_front();
            d = tick - int'(e[31:0]);
            cmp("left word", 32'(e[79:56]), 32'(got_l));
            cmp("right word", 32'(e[55:32]), 32'(got_r));
            cmp("latency", 32'h1, 32'(d >= lat_of(cfg.speed) && d <= lat_of(cfg.speed) + 3));
        end
    end
    always @(posedge mclk) begin
        if (srst || !cfg.master) run_len <= 0;
        else if (bclk_out !== prev_b) begin
            if (run_len > 0) cmp(prev_b ? "bclk high" : "bclk low", prev_b ?
                (cfg.divider_duty_select ? 32'(DIV33_HI) : 32'(DIV50_HI)) :
                (cfg.divider_duty_select ? 32'(DIV33_LO) : 32'(DIV50_LO)), run_len);
            run_len <= 1;
        end else if (run_len > 0) run_len <= run_len + 1;
        prev_b <= bclk_out;
    end
    always @(posedge bclk_w) begin
        if (fc_prev && !fc_w) begin
            if (nb > 0) cmp("bclk per frame", BCLK_PER_FRAME, nb);
            nb = 1;
        end else if (nb > 0) nb++;
        fc_prev = fc_w;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            $display("MISMATCH run time expected done seen running");
            close_out();
        end
    end
    // =====================================================================
    // Stimulus
    task automatic run_cfg(input logic [5:0] c, input int n, input int ovr_at);
        int sp;
        logic [SAMPLE_BITS+15:0] acc_l, acc_r;
        logic [SAMPLE_BITS-1:0] el, er;
        @(posedge mclk);
        #1 srst = 1'b1;
        cfg = asout_cfg_t'(c);
        gen = 1'b0;
        nb = 0;
        started = 1'b0;
        acc_l = '0;
        acc_r = '0;
        sp = !cfg.master ? 512 : (cfg.divider_duty_select ? 192 : 128);
        repeat (3) @(posedge mclk);
        #1 srst = 1'b0;
        cmp("bclk reset", 32'h0, 32'(bclk_out));
        cmp("frame reset", 32'h1, 32'(fc_out));
        cmp("data reset", 32'h0, 32'(sdata));
        cmp("flag reset", 32'h0, 32'(ovf));
        cmp("bclk enable", 32'(cfg.master), 32'(bclk_oe));
        cmp("frame enable", 32'(cfg.master), 32'(fc_oe));
        gen = !cfg.master;
        for (int i = 0; i < n + lat_of(cfg.speed) + 4; i++) begin
            @(posedge mclk);
            #1 smp_valid = 1'b1;
            tick++;
            smp = '0;
            if (i < n) begin
                smp.left = 24'($urandom()) | 24'h000001;
                smp.right = 24'($urandom());
                smp.overrange = (i == ovr_at);
            end
            el = smp.left;
            er = smp.right;
            if (cfg.hpf_enable) begin
                // Offset tracker model: one pole, weight 2^-HPF_SHIFT per sample
                el = smp.left - acc_l[SAMPLE_BITS+15:16];
                er = smp.right - acc_r[SAMPLE_BITS+15:16];
                acc_l = acc_l + (SAMPLE_BITS+16)'($signed({el, 16'h0000}) >>> HPF_SHIFT);
                acc_r = acc_r + (SAMPLE_BITS+16)'($signed({er, 16'h0000}) >>> HPF_SHIFT);
            end
            if (i < n) exp_q.push_back({el, er, 32'(tick)});
            @(posedge mclk);
            #1 smp_valid = 1'b0;
            repeat (sp - 2) @(posedge mclk);
        end
        cmp("samples left over", 32'h0, 32'(exp_q.size()));
        cmp("overrange held", 32'(ovr_at >= 0), 32'(ovf));
    endtask : run_cfg
    initial begin
        void'($urandom(32'h6f2e));
        run_cfg(6'b100000, 6, 2);
        run_cfg(6'b111001, 6, -1);
        run_cfg(6'b010000, 6, -1);
        // Quad-speed run last: high-pass off, so its flush frames carry zeros
        run_cfg(6'b101010, 6, -1);
        close_out();
    end
endmodule : tb
